// file: dv/parallel_byte_config_port_tb.sv
// self-checking bench of the parallel byte config port
`timescale 1ns/1ps
module parallel_byte_config_port_tb;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
  logic wb_ack_o, config_clock_o, config_clock_oe;
  logic init_ready_n = 1'b0, cfg_ready = 1'b1, cfg_last = 1'b0;
  logic [2:0] mode_select = 3'h1;
  logic [7:0] rb_byte = 8'h00, data_o, cfg_byte, host_data;
  logic rb_valid = 1'b0, config_error_n = 1'b1;
  logic sync_aligned = 1'b0, readback_active = 1'b0;
  logic data_oe, busy_o, busy_oe, done_o, cfg_valid, rb_take;
  logic host_clk, host_sel_n, host_rw;
  wire logic [7:0] data_i;
  wire logic host_busy;
  int err_count = 0, checks = 0, nacc = 0, nrb = 0;
  logic [31:0] seed = 32'h6e75160a;
  logic [7:0] q[$];

  // bus wire: device drives when enabled, else the host side
  assign data_i = data_oe ? data_o : host_data;
  assign host_busy = busy_oe ? busy_o : 1'bz;

  always #50 mclk = ~mclk;

  pbc_config_port dut (.mclk(mclk), .sys_rst(sys_rst),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .config_clock_i(host_clk), .config_clock_o(config_clock_o),
    .config_clock_oe(config_clock_oe), .init_ready_n(init_ready_n),
    .port_select_n(host_sel_n), .read_write_select_n(host_rw),
    .mode_select(mode_select), .data_i(data_i), .data_o(data_o),
    .data_oe(data_oe), .busy_o(busy_o), .busy_oe(busy_oe),
    .done_o(done_o), .cfg_byte(cfg_byte), .cfg_valid(cfg_valid),
    .cfg_ready(cfg_ready), .cfg_last(cfg_last), .rb_byte(rb_byte),
    .rb_valid(rb_valid), .rb_take(rb_take),
    .config_error_n(config_error_n), .sync_aligned(sync_aligned),
    .readback_active(readback_active));

  pbc_host_model host (.mclk(mclk), .busy(host_busy),
    .config_clock(host_clk), .port_select_n(host_sel_n),
    .read_write_select_n(host_rw), .data(host_data));

  // --------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  // pin zero is the msb, so the pin bus reads bit-reversed
  function automatic logic [7:0] rev8(input logic [7:0] b);
    for (int i = 0; i < 8; i++)
      rev8[i] = b[7 - i];
  endfunction : rev8

  task complete_run;
    if (err_count == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : complete_run

  task check(input string what, input logic [31:0] seen, exp);
    checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task give_up(input string what);
    err_count++;
    $display("unexpected %s: no answer in time", what);
    complete_run();
  endtask : give_up

  // classic single cycle, held until ack is sampled high
  task wb(input logic we, input logic [3:0] a, input logic [31:0] d,
    output logic [31:0] r);
    int n;
    @(posedge mclk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_sel_i <= 4'hF;
    wb_dat_i <= d;
    for (n = 0; n < 20 && wb_ack_o !== 1'b1; n++)
      @(posedge mclk);
    if (wb_ack_o !== 1'b1)
      give_up("wishbone ack");
    r = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb

  // queue first: the byte may surface before the host task returns
  task send(input logic [7:0] d);
    logic ok;
    q.push_back(rev8(d));
    host.put(d, ok);
    if (!ok)
      give_up("byte accept");
    nacc++;
  endtask : send

  // every accepted byte matches the oldest byte the host got through
  always @(posedge mclk)
    if (cfg_valid === 1'b1)
    begin
      if (q.size() == 0)
        check("stray byte", 32'(cfg_byte), 32'h100);
      else
        check("cfg_byte", 32'(cfg_byte), 32'(q.pop_front()));
    end

  // readback bytes handed over to the host side
  always @(posedge mclk)
    if (rb_take === 1'b1)
      nrb++;

  // --------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------
  initial
  begin
    logic [31:0] r;
    logic b;
    logic c;
    int t;
    repeat (8) @(posedge mclk);
    sys_rst <= 1'b0;
    wb(1'b0, pbc_pkg::ADDR_CTRL, 32'h0, r);
    check("ctrl reset", r, pbc_pkg::CTRL_RESET);
    wb(1'b1, pbc_pkg::ADDR_CTRL, 32'h0000_0201, r);
    wb(1'b0, pbc_pkg::ADDR_CTRL, 32'h0, r);
    check("ctrl", r, 32'h0000_0201);
    wb(1'b1, 4'hC, 32'hFFFF_FFFF, r);
    wb(1'b0, 4'hC, 32'h0, r);
    check("hole", r, 32'h0);
    check("idle pins", 32'({data_oe, busy_oe}), 32'h0);
    // selected writes before init are ignored, busy already low
    repeat (3) host.cycle(1'b0, 1'b0, 8'hA5, b);
    check("early busy", 32'({busy_oe, busy_o}), 32'h2);
    check("slave clock", 32'(config_clock_oe), 32'h0);
    init_ready_n <= 1'b1;
    for (int i = 0; i < 12; i++)
    begin
      seed = lfsr(seed);
      send(seed[7:0]);
    end
    // processor stall: busy rises and the bus byte is dropped
    cfg_ready <= 1'b0;
    repeat (2) host.cycle(1'b0, 1'b0, 8'h3C, b);
    check("stall busy", 32'(busy_o), 32'h1);
    cfg_ready <= 1'b1;
    send(8'h3C);
    // direction wiggle in a clock halt, then while deselected
    host.pins(1'b0, 1'b1);
    host.pins(1'b0, 1'b0);
    send(8'h81);
    host.pins(1'b1, 1'b0);
    host.pins(1'b1, 1'b1);
    repeat (4) @(posedge mclk);
    check("float", 32'({data_oe, busy_oe}), 32'h0);
    // readback: busy high on selection, then reversed bytes
    rb_byte <= seed[15:8];
    rb_valid <= 1'b1;
    host.cycle(1'b0, 1'b1, 8'h00, b);
    // the data driver turns on one cycle after the state moves
    @(posedge mclk);
    check("rb busy", 32'({data_oe, busy_oe, busy_o}), 32'h7);
    b = 1'b1;
    for (int i = 0; i < 8 && b; i++)
    begin
      host.cycle(1'b0, 1'b1, 8'h00, b);
      b = (busy_o !== 1'b0);
    end
    if (b)
      give_up("readback busy");
    repeat (20) @(posedge mclk);
    check("rb data", 32'(data_o), 32'(rev8(rb_byte)));
    // abort: direction flips at a selected edge, status in read
    host.pins(1'b1, 1'b1);
    host.pins(1'b1, 1'b0);
    send(8'h5A);
    {config_error_n, sync_aligned, readback_active} <= seed[18:16];
    repeat (2) host.cycle(1'b0, 1'b1, 8'h00, b);
    check("abort busy", 32'(busy_o), 32'h1);
    check("status", 32'(data_o),
      32'({config_error_n, sync_aligned, readback_active, 5'h0F}));
    repeat (3) host.cycle(1'b0, 1'b1, 8'h00, b);
    host.pins(1'b1, 1'b1);
    host.pins(1'b1, 1'b0);
    send(8'hC3);
    // last byte starts startup; done rises within it
    cfg_last <= 1'b1;
    send(8'hF0);
    check("done early", 32'(done_o), 32'h0);
    repeat (6) host.cycle(1'b0, 1'b0, 8'hFF, b);
    check("done", 32'(done_o), 32'h1);
    host.pins(1'b1, 1'b0);
    repeat (4) @(posedge mclk);
    wb(1'b0, pbc_pkg::ADDR_COUNT, 32'h0, r);
    check("byte count", 32'(r[15:0]), 32'(nacc));
    check("queue left", 32'(q.size()), 32'h0);
    check("rb take", 32'(nrb), 32'h1);
    // mid-run reset restraps the port as clock master
    sys_rst <= 1'b1;
    mode_select <= pbc_pkg::MODE_MASTER;
    repeat (8) @(posedge mclk);
    sys_rst <= 1'b0;
    repeat (6) @(posedge mclk);
    check("master oe", 32'(config_clock_oe), 32'h1);
    c = config_clock_o;
    t = 0;
    repeat (16)
    begin
      @(posedge mclk);
      if (config_clock_o !== c)
        t++;
      c = config_clock_o;
    end
    // one toggle per half period of the reset divider setting
    check("master clock", 32'(t), 32'(16 / pbc_pkg::MASTER_HALF_DEF));
    complete_run();
  end
endmodule : parallel_byte_config_port_tb

// file: dv/pbc_host_model.sv
// host-side model that drives the config pins in slave mode
`timescale 1ns/1ps
module pbc_host_model
(
  input wire logic mclk,
  input wire logic busy,
  output logic config_clock,
  output logic port_select_n,
  output logic read_write_select_n,
  output logic [7:0] data
);
  logic [7:0] last = 8'h00;

  // idle: deselected, write direction, clock halted low
  initial
  begin
    config_clock = 1'b0;
    port_select_n = 1'b1;
    read_write_select_n = 1'b0;
    data = 8'hFF;
  end

  // pin change with the clock halted; one device selected at a time
  task pins(input logic sn, input logic rw);
    @(posedge mclk);
    port_select_n <= sn;
    read_write_select_n <= rw;
    data <= ~last; // released bus must not show the stale byte
  endtask : pins

  // one 900 ns clock (500 ns low, 400 ns high), far below the unhandshaked limit
  task cycle(input logic sn, input logic rw, input logic [7:0] d,
    output logic b);
    @(posedge mclk);
    port_select_n <= sn;
    read_write_select_n <= rw;
    if (!sn && !rw)
      last = d;
    data <= (!sn && !rw) ? d : ~last;
    repeat (4) @(posedge mclk);
    b = busy;
    config_clock <= 1'b1;
    repeat (4) @(posedge mclk);
    config_clock <= 1'b0;
  endtask : cycle

  // busy watched on every byte; a refused byte is presented again
  task put(input logic [7:0] d, output logic ok);
    logic b;
    ok = 1'b0;
    for (int i = 0; i < 16 && !ok; i++)
    begin
      cycle(1'b0, 1'b0, d, b);
      ok = (b === 1'b0);
    end
  endtask : put
endmodule : pbc_host_model

// file: rtl/pbc_config_port.sv
// byte-wide configuration and readback port with wishbone control
//
// The Wishbone register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps

module pbc_config_port
(
  input wire logic mclk,
  input wire logic sys_rst,
  // wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // pins
  input wire logic config_clock_i,
  output logic config_clock_o,
  output logic config_clock_oe,
  input wire logic init_ready_n,
  input wire logic port_select_n,
  input wire logic read_write_select_n,
  input wire logic [2:0] mode_select,
  input wire logic [7:0] data_i,
  output logic [7:0] data_o,
  output logic data_oe,
  output logic busy_o,
  output logic busy_oe,
  output logic done_o,
  // internal packet processor side
  output logic [7:0] cfg_byte,
  output logic cfg_valid,
  input wire logic cfg_ready,
  input wire logic cfg_last,
  input wire logic [7:0] rb_byte,
  input wire logic rb_valid,
  output logic rb_take,
  input wire logic config_error_n,
  input wire logic sync_aligned,
  input wire logic readback_active
);

  // -------------------------------------------------------------------
  // pin synchronisers
  // -------------------------------------------------------------------
  pbc_pkg::pbc_pins_type pin_raw;
  pbc_pkg::pbc_pins_type pin_meta_reg;
  pbc_pkg::pbc_pins_type pin_sync_reg;
  logic config_clock_prev_reg;

  assign pin_raw = {config_clock_i, init_ready_n, port_select_n,
                    read_write_select_n, mode_select, data_i};

  // meta stage is read by the sync stage only
  always_ff @(posedge mclk)
  begin
    pin_meta_reg <= pin_raw;
    pin_sync_reg <= pin_meta_reg;
    config_clock_prev_reg <= pin_sync_reg.config_clock;
  end

  // -------------------------------------------------------------------
  // wishbone registers
  // -------------------------------------------------------------------
  logic [31:0] ctrl_reg;
  logic [15:0] count_reg;
  logic ack_reg;
  logic [31:0] rdata_reg;
  pbc_pkg::pbc_state_type state_reg;
  logic master_reg;
  logic done_reg;
  logic [3:0] abort_seen_reg;

  wire wb_take = wb_cyc_i & wb_stb_i & ~ack_reg;
  wire wr_ctrl = wb_take & wb_we_i & (wb_adr_i == pbc_pkg::ADDR_CTRL);
  wire port_en = ctrl_reg[pbc_pkg::CTRL_EN_BIT];
  wire [7:0] half_cnt = ctrl_reg[pbc_pkg::CTRL_HALF_LSB +: 8];
  wire [31:0] status_word = {20'h00000, abort_seen_reg, 1'b0,
                             master_reg, done_reg, 1'b0, 1'b0,
                             state_reg};
  wire [31:0] rdata_next =
    (wb_adr_i == pbc_pkg::ADDR_CTRL) ? ctrl_reg :
    (wb_adr_i == pbc_pkg::ADDR_STATUS) ? status_word :
    (wb_adr_i == pbc_pkg::ADDR_COUNT) ? {16'h0000, count_reg} :
    32'h00000000; // unmapped reads zero, still acked

  // one-cycle ack, byte lanes honoured on the control word
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      ack_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      ctrl_reg <= pbc_pkg::CTRL_RESET;
    end
    else
    begin
      ack_reg <= wb_take;
      rdata_reg <= rdata_next;
      for (int b = 0; b < 4; b++)
        if (wr_ctrl && wb_sel_i[b])
          ctrl_reg[b*8 +: 8] <= wb_dat_i[b*8 +: 8];
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdata_reg;

  // -------------------------------------------------------------------
  // config clock: generated in master mode, sampled in slave mode
  // -------------------------------------------------------------------
  logic [7:0] div_reg;
  logic config_clock_out_reg;
  wire div_wrap = (div_reg + 8'h01 >= half_cnt);
  wire master_rise = master_reg & div_wrap & ~config_clock_out_reg;
  wire slave_rise = pin_sync_reg.config_clock & ~config_clock_prev_reg;
  wire config_clock_rise = port_en & (master_reg ? master_rise : slave_rise);

  // divider only runs once master mode was strapped
  always_ff @(posedge mclk)
  begin
    if (sys_rst || !master_reg)
    begin
      div_reg <= 8'h00;
      config_clock_out_reg <= 1'b0;
    end
    else if (div_wrap)
    begin
      div_reg <= 8'h00;
      config_clock_out_reg <= ~config_clock_out_reg;
    end
    else
      div_reg <= div_reg + 8'h01;
  end

  assign config_clock_o = config_clock_out_reg;

  // -------------------------------------------------------------------
  // port sequencer
  // -------------------------------------------------------------------
  logic [3:0] cnt_reg;
  logic dir_reg;
  logic busy_reg;
  logic [7:0] dout_reg;
  logic dout_en_reg;
  logic busy_en_reg;
  logic [7:0] cfg_byte_reg;
  logic cfg_valid_reg;
  logic rb_take_reg;

  wire sel = ~pin_sync_reg.port_select_n;
  wire rd = pin_sync_reg.read_write_select_n;
  wire live = (state_reg != pbc_pkg::ST_WAIT_INIT);
  wire abort_hit = config_clock_rise & sel & live & (rd != dir_reg) &
                   (state_reg != pbc_pkg::ST_ABORT);
  wire write_take = config_clock_rise & sel & ~rd & ~busy_reg & cfg_ready &
                    ((state_reg == pbc_pkg::ST_IDLE) |
                     (state_reg == pbc_pkg::ST_ACTIVE));
  wire cnt_last_abort = (cnt_reg == pbc_pkg::ABORT_CYCLES - 4'h1);
  wire cnt_last_start = (cnt_reg == pbc_pkg::STARTUP_CYCLES - 4'h1);
  wire cnt_last_sel = (cnt_reg == pbc_pkg::SELECT_BUSY_CYCLES - 4'h1);
  // the edge that drops busy after selection already presents a byte
  wire read_give = config_clock_rise & sel & rd & rb_valid &
                   ((state_reg == pbc_pkg::ST_ACTIVE) |
                    ((state_reg == pbc_pkg::ST_SWITCH) & cnt_last_sel));
  // an aborting edge passes nothing on, so the count stays honest
  wire byte_take = write_take & ~abort_hit;
  // direction follows freely while deselected, so no false abort
  wire dir_load = live & (config_clock_rise | ~sel);
  wire [7:0] data_msb = {<<{pin_sync_reg.data}};
  wire [7:0] rb_pins = {<<{rb_byte}};
  wire [7:0] abort_status = {config_error_n, sync_aligned,
                             readback_active, 1'b0,
                             pbc_pkg::STAT_LOW_FILL};

  pbc_pkg::pbc_state_type state_next;
  logic [3:0] cnt_next;
  logic busy_next;

  // next state, evaluated on config clock rises except the init wait and the deselect fallback
  always_comb
  begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    busy_next = busy_reg;
    case (state_reg)
      pbc_pkg::ST_WAIT_INIT:
        if (port_en && pin_sync_reg.init_ready_n)
          state_next = pbc_pkg::ST_IDLE;
      pbc_pkg::ST_IDLE:
        if (config_clock_rise && sel && rd)
        begin
          state_next = pbc_pkg::ST_SWITCH;
          cnt_next = 4'h0;
          busy_next = 1'b1;
        end
        else if (config_clock_rise && sel)
        begin
          state_next = pbc_pkg::ST_ACTIVE;
          busy_next = ~cfg_ready;
        end
      pbc_pkg::ST_SWITCH:
        if (config_clock_rise)
        begin
          cnt_next = cnt_reg + 4'h1;
          if (cnt_last_sel)
          begin
            state_next = pbc_pkg::ST_ACTIVE;
            busy_next = ~rb_valid;
          end
        end
      pbc_pkg::ST_ACTIVE:
        if (byte_take && cfg_last)
        begin
          state_next = pbc_pkg::ST_STARTUP;
          cnt_next = 4'h0;
        end
        else if (config_clock_rise)
          busy_next = rd ? ~rb_valid : ~cfg_ready;
      pbc_pkg::ST_ABORT:
        if (config_clock_rise)
        begin
          cnt_next = cnt_reg + 4'h1;
          if (cnt_last_abort)
          begin
            state_next = pbc_pkg::ST_IDLE;
            busy_next = 1'b0;
          end
        end
      pbc_pkg::ST_STARTUP:
        if (config_clock_rise)
        begin
          cnt_next = cnt_reg + 4'h1;
          if (cnt_last_start)
            state_next = pbc_pkg::ST_IDLE;
        end
      default:
        state_next = pbc_pkg::ST_WAIT_INIT;
    endcase
    // a deselected port falls back to idle from the switch and active states only
    if (!sel && ((state_reg == pbc_pkg::ST_ACTIVE) ||
                 (state_reg == pbc_pkg::ST_SWITCH)))
    begin
      state_next = pbc_pkg::ST_IDLE;
      busy_next = 1'b0;
    end
    if (abort_hit)
    begin
      state_next = pbc_pkg::ST_ABORT;
      cnt_next = 4'h0;
      busy_next = 1'b1;
    end
  end

  // state, straps and the captured direction
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      state_reg <= pbc_pkg::ST_WAIT_INIT;
      cnt_reg <= 4'h0;
      busy_reg <= 1'b0;
      master_reg <= 1'b0;
      dir_reg <= 1'b0;
      done_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      busy_reg <= busy_next;
      if (!live && state_next == pbc_pkg::ST_IDLE)
      begin
        master_reg <= (pin_sync_reg.mode_select ==
                       pbc_pkg::MODE_MASTER);
        dir_reg <= rd;
      end
      if (dir_load)
        dir_reg <= rd;
      if (config_clock_rise && state_reg == pbc_pkg::ST_STARTUP &&
          cnt_reg == pbc_pkg::STARTUP_DONE_AT)
        done_reg <= 1'b1;
    end
  end

  // pin drivers: enables drop one cycle after a deselect passes the synchronisers
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      dout_reg <= 8'h00;
      dout_en_reg <= 1'b0;
      busy_en_reg <= 1'b0;
    end
    else
    begin
      busy_en_reg <= sel;
      dout_en_reg <= sel & rd & live & (state_reg != pbc_pkg::ST_IDLE)
                     & (state_reg != pbc_pkg::ST_STARTUP);
      if (config_clock_rise && state_next == pbc_pkg::ST_ABORT && rd)
        dout_reg <= abort_status;
      else if (read_give)
        dout_reg <= rb_pins;
    end
  end

  // accepted byte handed on once per taking edge
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      cfg_byte_reg <= 8'h00;
      cfg_valid_reg <= 1'b0;
      rb_take_reg <= 1'b0;
      count_reg <= 16'h0000;
      abort_seen_reg <= 4'h0;
    end
    else
    begin
      cfg_valid_reg <= byte_take;
      rb_take_reg <= read_give & ~abort_hit;
      if (byte_take)
      begin
        cfg_byte_reg <= data_msb;
        count_reg <= count_reg + 16'h0001;
      end
      if (abort_hit)
        abort_seen_reg <= abort_seen_reg + 4'h1;
    end
  end

  assign config_clock_oe = master_reg;
  assign data_o = dout_reg;
  assign data_oe = dout_en_reg;
  assign busy_o = busy_reg;
  assign busy_oe = busy_en_reg;
  assign done_o = done_reg;
  assign cfg_byte = cfg_byte_reg;
  assign cfg_valid = cfg_valid_reg;
  assign rb_take = rb_take_reg;

  // -------------------------------------------------------------------
  // assertions
  // -------------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  float_desel_a: assert property (pin_sync_reg.port_select_n |=>
    !data_oe && !busy_oe) else $error("pins driven while deselected");
  msb_first_a: assert property (cfg_valid |->
    cfg_byte[7] == $past(pin_sync_reg.data[0]))
    else $error("byte bit order wrong");
  wait_ignore_a: assert property (state_reg == pbc_pkg::ST_WAIT_INIT
    |=> !cfg_valid && !rb_take) else $error("port active before init");
  abort_trig_a: assert property (abort_hit |=>
    state_reg == pbc_pkg::ST_ABORT && cnt_reg == 4'h0)
    else $error("direction change did not abort");
  abort_len_a: assert property (state_reg == pbc_pkg::ST_ABORT |->
    cnt_reg < pbc_pkg::ABORT_CYCLES) else $error("abort too long");
  status_byte_a: assert property (config_clock_rise && rd &&
    state_next == pbc_pkg::ST_ABORT |=>
    data_o[3:0] == pbc_pkg::STAT_LOW_FILL && !data_o[4])
    else $error("abort status byte wrong");
  single_take_a: assert property (cfg_valid |=> !cfg_valid)
    else $error("byte accepted twice");
  sel_only_a: assert property (cfg_valid |->
    $past(sel && !rd && !busy_reg)) else $error("byte taken unselected");
  done_start_a: assert property ($rose(done_o) |->
    $past(state_reg == pbc_pkg::ST_STARTUP))
    else $error("done outside startup");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held too long");

  abort_c: cover property (state_reg == pbc_pkg::ST_ABORT && cnt_last_abort);
  take_c: cover property (cfg_valid ##[1:40] cfg_valid);
  read_c: cover property (rb_take);
  done_c: cover property ($rose(done_o));

endmodule : pbc_config_port

// file: rtl/pbc_pkg.sv
// shared constants, states and pin carriers of the parallel config port
package pbc_pkg;

  // -------------------------------------------------------------------
  // clock and timing
  // -------------------------------------------------------------------
  localparam int MCLK_HZ = 10_000_000;
  localparam int MASTER_CONFIG_CLOCK_NS = 800;
  localparam int MCLK_NS = 1_000_000_000 / MCLK_HZ;
  localparam logic [7:0] MASTER_HALF_DEF =
    8'((MASTER_CONFIG_CLOCK_NS / 2 + MCLK_NS - 1) / MCLK_NS);
  localparam logic [3:0] ABORT_CYCLES = 4'h4;
  localparam logic [3:0] STARTUP_CYCLES = 4'h8;
  localparam logic [3:0] STARTUP_DONE_AT = 4'h4;
  localparam logic [3:0] SELECT_BUSY_CYCLES = 4'h2;

  // -------------------------------------------------------------------
  // mode straps and status byte layout (bit index = pin number)
  // -------------------------------------------------------------------
  localparam logic [2:0] MODE_MASTER = 3'h0;
  localparam int STAT_ERR_BIT = 7;
  localparam int STAT_SYNC_BIT = 6;
  localparam int STAT_RB_BIT = 5;
  localparam int STAT_ABORT_BIT = 4;
  localparam logic [3:0] STAT_LOW_FILL = 4'hF;

  // -------------------------------------------------------------------
  // wishbone register map
  // -------------------------------------------------------------------
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_COUNT = 4'h8;
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_HALF_LSB = 8;
  localparam logic [31:0] CTRL_RESET = {16'h0000, MASTER_HALF_DEF, 8'h01};

  typedef enum logic [2:0] {
    ST_WAIT_INIT,
    ST_IDLE,
    ST_SWITCH,
    ST_ACTIVE,
    ST_ABORT,
    ST_STARTUP
  } pbc_state_type;

  typedef struct packed {
    logic config_clock;
    logic init_ready_n;
    logic port_select_n;
    logic read_write_select_n;
    logic [2:0] mode_select;
    logic [7:0] data;
  } pbc_pins_type;

endpackage : pbc_pkg
